//--- design/atc_core_seq.sv
// Sample and convert sequencer of one dedicated conversion core
`timescale 1ns/1ps
`include "atc_defs.svh"
module atc_core_seq
(
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic                     trig,
  input  wire atc_pkg::atc_core_cfg_t   cfg,
  input  wire logic                     core_tick,
  input  wire logic [`ATC_EXTENDED_SAMPLE_TIME_W-1:0]   sample_time,
  input  wire logic                     conv_done,
  output logic                          sampling,
  output logic                          conv_start,
  output logic                          conv_busy
);
  import atc_pkg::*;

  atc_core_state_t         state_ff;
  atc_core_state_t         nxt_state;
  logic [`ATC_EXTENDED_SAMPLE_TIME_W-1:0]  cnt_ff;
  logic [`ATC_EXTENDED_SAMPLE_TIME_W-1:0]  nxt_cnt;
  logic                    pend_ff;
  logic                    nxt_pend;
  logic                    start_ff;
  logic                    nxt_start;
  logic                    launch;

  // ----------------------------------------
  // Trigger launch
  // ----------------------------------------
  // Synchronized triggers wait for the next core clock tick; unsynchronized ones launch at once
  assign launch = (state_ff == ATC_SAMPLING) &&
                  (cfg.sync_en ? (core_tick && (pend_ff || trig)) : trig);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_start = 1'b0;
    nxt_pend  = pend_ff;
    if (state_ff == ATC_SAMPLING && cfg.sync_en && trig && !core_tick)
    begin
      nxt_pend = 1'b1;
    end
    case (state_ff)
      ATC_SAMPLING:
      begin
        if (launch)
        begin
          nxt_pend = 1'b0;
          if (cfg.delay_en)
          begin
            nxt_state = ATC_EXTEND;
            nxt_cnt   = sample_time;
          end
          else
          begin
            nxt_state = ATC_WAIT_CLK;
          end
        end
      end
      ATC_EXTEND:
      begin
        if (core_tick)
        begin
          if (cnt_ff == '0)
          begin
            nxt_state = ATC_CONVERT;
            nxt_start = 1'b1;
          end
          else
          begin
            nxt_cnt = cnt_ff - 1'b1;
          end
        end
      end
      ATC_WAIT_CLK:
      begin
        if (core_tick)
        begin
          nxt_state = ATC_CONVERT;
          nxt_start = 1'b1;
        end
      end
      ATC_CONVERT:
      begin
        if (conv_done)
        begin
          nxt_state = ATC_SAMPLING;
        end
      end
      default:
      begin
        nxt_state = ATC_SAMPLING;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= ATC_SAMPLING;
      cnt_ff   <= '0;
      pend_ff  <= 1'b0;
      start_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      pend_ff  <= nxt_pend;
      start_ff <= nxt_start;
    end
  end

  assign sampling   = (state_ff == ATC_SAMPLING) || (state_ff == ATC_EXTEND);
  assign conv_start = start_ff;
  assign conv_busy  = (state_ff == ATC_CONVERT);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_launch_nodly;
    (state_ff == ATC_SAMPLING) && launch && !cfg.delay_en;
  endsequence

  property p_stop_at_once;
    @(posedge aclk) disable iff (!aresetn)
    s_launch_nodly |=> !sampling ##0 (state_ff == ATC_WAIT_CLK);
  endproperty
  a_stop_at_once: assert property (p_stop_at_once) else $error("sampling not stopped on trigger");

  property p_conv_next_tick;
    @(posedge aclk) disable iff (!aresetn)
    (state_ff == ATC_WAIT_CLK) && core_tick |=> conv_start && conv_busy;
  endproperty
  a_conv_next_tick: assert property (p_conv_next_tick) else $error("conversion not started on tick");

  property p_extend_keeps;
    @(posedge aclk) disable iff (!aresetn)
    (state_ff == ATC_SAMPLING) && launch && cfg.delay_en |=> sampling && !conv_start;
  endproperty
  a_extend_keeps: assert property (p_extend_keeps) else $error("delayed trigger stopped sampling");

  property p_extend_end;
    @(posedge aclk) disable iff (!aresetn)
    (state_ff == ATC_EXTEND) && core_tick && (cnt_ff != '0) |=> !conv_start ##0 ($past(cnt_ff) == cnt_ff + 1'b1);
  endproperty
  a_extend_end: assert property (p_extend_end) else $error("sample time cut short");

  property p_sync_waits;
    @(posedge aclk) disable iff (!aresetn)
    (state_ff == ATC_SAMPLING) && cfg.sync_en && trig && !core_tick |=> pend_ff ##0 (state_ff == ATC_SAMPLING);
  endproperty
  a_sync_waits: assert property (p_sync_waits) else $error("synchronized trigger did not wait");

  property p_unsync_direct;
    @(posedge aclk) disable iff (!aresetn)
    (state_ff == ATC_SAMPLING) && !cfg.sync_en && trig |=> (state_ff != ATC_SAMPLING);
  endproperty
  a_unsync_direct: assert property (p_unsync_direct) else $error("unsynchronized trigger delayed");
endmodule : atc_core_seq

//--- design/atc_defs.svh
// Register map, field positions and reset values of the trigger conditioning block
`ifndef ATC_DEFS_SVH
`define ATC_DEFS_SVH
`define ATC_ADDR_SYNC_DELAY 4'h0
`define ATC_ADDR_SENS       4'h4
`define ATC_SYNC_LSB        8
`define ATC_DLY_LSB         0
`define ATC_CTRL_MASK       16'h0303
`define ATC_SENS_MASK       16'h4FFF
`define ATC_REG_RST         16'h0000
`define ATC_RESP_OKAY       2'h0
`define ATC_RESP_SLVERR     2'h2
`define ATC_NUM_CORES       2
`define ATC_NUM_CHAN        15
`define ATC_EXTENDED_SAMPLE_TIME_W          10
`endif

//--- design/atc_pkg.sv
// Types shared by the trigger conditioning block
package atc_pkg;
  typedef struct packed
  {
    logic sync_en;
    logic delay_en;
  } atc_core_cfg_t;

  typedef enum logic [1:0]
  {
    ATC_SAMPLING,
    ATC_EXTEND,
    ATC_WAIT_CLK,
    ATC_CONVERT
  } atc_core_state_t;
endpackage : atc_pkg

//--- design/atc_trigger_cond.sv
// Trigger conditioning top: AXI4-Lite registers, channel edge/level conditioning, core sequencers
`timescale 1ns/1ps
`include "atc_defs.svh"
module atc_trigger_cond
#(
  parameter int NUM_CHAN  = `ATC_NUM_CHAN,
  parameter int NUM_CORES = `ATC_NUM_CORES
)
(
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  input  wire logic [3:0]                          s_axi_awaddr,
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  input  wire logic [31:0]                         s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  output logic [1:0]                               s_axi_bresp,
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  input  wire logic [3:0]                          s_axi_araddr,
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  output logic [31:0]                              s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  input  wire logic [NUM_CHAN-1:0]                 trig_src,
  output logic [NUM_CHAN-1:0]                      chan_trig_req,
  input  wire logic [NUM_CORES-1:0]                core_tick,
  input  wire logic [NUM_CORES*`ATC_EXTENDED_SAMPLE_TIME_W-1:0]    extended_sample_time,
  input  wire logic [NUM_CORES-1:0]                conv_done,
  output logic [NUM_CORES-1:0]                     core_sampling,
  output logic [NUM_CORES-1:0]                     core_conv_start,
  output logic [NUM_CORES-1:0]                     core_conv_busy
);
  import atc_pkg::*;

  logic [15:0]          ctrl_ff;
  logic [15:0]          nxt_ctrl;
  logic [15:0]          sens_ff;
  logic [15:0]          nxt_sens;
  logic                 bvalid_ff;
  logic                 nxt_bvalid;
  logic [1:0]           bresp_ff;
  logic [1:0]           nxt_bresp;
  logic                 rvalid_ff;
  logic                 nxt_rvalid;
  logic [31:0]          rdata_ff;
  logic [31:0]          nxt_rdata;
  logic [1:0]           rresp_ff;
  logic [1:0]           nxt_rresp;
  logic                 wr_go;
  logic                 rd_go;
  logic [15:0]          wmask;
  logic [NUM_CHAN-1:0]  meta_ff;
  logic [NUM_CHAN-1:0]  sync_ff;
  logic [NUM_CHAN-1:0]  prev_ff;
  logic [NUM_CHAN-1:0]  req_ff;
  logic [NUM_CHAN-1:0]  nxt_req;
  logic [NUM_CHAN-1:0]  level_sel;

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  // Address and data are taken together; the master holds each valid until its ready
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
  assign rd_go         = s_axi_arvalid && !rvalid_ff;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign wmask         = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  always_comb
  begin
    nxt_ctrl   = ctrl_ff;
    nxt_sens   = sens_ff;
    nxt_bvalid = bvalid_ff && !s_axi_bready;
    nxt_bresp  = bresp_ff;
    nxt_rvalid = rvalid_ff && !s_axi_rready;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (wr_go)
    begin
      nxt_bvalid = 1'b1;
      nxt_bresp  = `ATC_RESP_OKAY;
      if (s_axi_awaddr == `ATC_ADDR_SYNC_DELAY)
      begin
        nxt_ctrl = ((s_axi_wdata[15:0] & wmask) | (ctrl_ff & ~wmask)) & `ATC_CTRL_MASK;
      end
      else if (s_axi_awaddr == `ATC_ADDR_SENS)
      begin
        nxt_sens = ((s_axi_wdata[15:0] & wmask) | (sens_ff & ~wmask)) & `ATC_SENS_MASK;
      end
      else
      begin
        nxt_bresp = `ATC_RESP_SLVERR;
      end
    end
    if (rd_go)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = `ATC_RESP_OKAY;
      if (s_axi_araddr == `ATC_ADDR_SYNC_DELAY)
      begin
        nxt_rdata = {16'h0000, ctrl_ff & `ATC_CTRL_MASK};
      end
      else if (s_axi_araddr == `ATC_ADDR_SENS)
      begin
        nxt_rdata = {16'h0000, sens_ff & `ATC_SENS_MASK};
      end
      else
      begin
        nxt_rdata = 32'h00000000;
        nxt_rresp = `ATC_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_ff   <= `ATC_REG_RST;
      sens_ff   <= `ATC_REG_RST;
      bvalid_ff <= 1'b0;
      bresp_ff  <= `ATC_RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= `ATC_RESP_OKAY;
    end
    else
    begin
      ctrl_ff   <= nxt_ctrl;
      sens_ff   <= nxt_sens;
      bvalid_ff <= nxt_bvalid;
      bresp_ff  <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  // ----------------------------------------
  // Channel conditioning
  // ----------------------------------------
  // Channels without a sensitivity bit read a zero there and so stay edge-sensitive
  assign level_sel = sens_ff[NUM_CHAN-1:0];

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++)
    begin : g_chan
      always_comb
      begin
        nxt_req[ch] = level_sel[ch] ? sync_ff[ch] : (sync_ff[ch] && !prev_ff[ch]);
      end
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
      req_ff  <= '0;
    end
    else
    begin
      meta_ff <= trig_src;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
      req_ff  <= nxt_req;
    end
  end

  assign chan_trig_req = req_ff;

  // ----------------------------------------
  // Dedicated cores
  // ----------------------------------------
  // Core n is fed by input channel n
  genvar co;
  generate
    for (co = 0; co < NUM_CORES; co++)
    begin : g_core
      atc_core_cfg_t cfg;
      assign cfg = '{sync_en: ctrl_ff[`ATC_SYNC_LSB + co], delay_en: ctrl_ff[`ATC_DLY_LSB + co]};
      atc_core_seq u_seq
      (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .trig        (req_ff[co]),
        .cfg         (cfg),
        .core_tick   (core_tick[co]),
        .sample_time (extended_sample_time[co*`ATC_EXTENDED_SAMPLE_TIME_W +: `ATC_EXTENDED_SAMPLE_TIME_W]),
        .conv_done   (conv_done[co]),
        .sampling    (core_sampling[co]),
        .conv_start  (core_conv_start[co]),
        .conv_busy   (core_conv_busy[co])
      );
    end
  endgenerate

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_edge_single;
    @(posedge aclk) disable iff (!aresetn)
    !level_sel[0] && req_ff[0] && $stable(level_sel[0]) |=> !req_ff[0];
  endproperty
  a_edge_single: assert property (p_edge_single) else $error("edge channel fired twice");

  property p_level_repeat;
    @(posedge aclk) disable iff (!aresetn)
    level_sel[14] && sync_ff[14] && $stable(level_sel[14]) |=> req_ff[14];
  endproperty
  a_level_repeat: assert property (p_level_repeat) else $error("level channel 14 not requesting");

  property p_ctrl_reserved;
    @(posedge aclk) disable iff (!aresetn)
    (ctrl_ff & ~`ATC_CTRL_MASK) == 16'h0000 && (sens_ff & ~`ATC_SENS_MASK) == 16'h0000;
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("reserved bits set");

  property p_read_upper_zero;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_read_upper_zero: assert property (p_read_upper_zero) else $error("read upper half not zero");
endmodule : atc_trigger_cond

//--- verification/adc_trigger_conditioning_tb.sv
// Self-checking testbench of the trigger conditioning block
`timescale 1ns/1ps
`include "atc_defs.svh"
module adc_trigger_conditioning_tb;
  import atc_pkg::*;
  logic aclk = 0, aresetn = 0, slow = 0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp, tick, done, smp, cstart, cbusy;
  logic [14:0] trig = 15'h0, req;
  int failures = 0, checks = 0;

  always #5 aclk = ~aclk;

  atc_trigger_cond u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .trig_src(trig),
    .chan_trig_req(req), .core_tick(tick), .extended_sample_time({10'h005, 10'h00A}),
    .conv_done(done), .core_sampling(smp), .core_conv_start(cstart), .core_conv_busy(cbusy));

  atc_core_model u_cores (.aclk(aclk), .aresetn(aresetn), .slow(slow), .core_conv_start(cstart),
    .core_tick(tick), .conv_done(done));

  task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_val

  task automatic chk_rng(input string name, input int lo, input int hi, input int got);
    checks++;
    if (got < lo || got > hi)
    begin
      failures++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask : chk_rng

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge aclk);
    while (!(awready === 1'b1 && wready === 1'b1))
      @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(posedge aclk);
    while (bvalid !== 1'b1)
      @(posedge aclk);
    bready <= 1'b0;
    chk_val("bresp", {30'h0, er}, {30'h0, bresp});
    // Let an edge pass so a following call does not raise bready in the same step
    @(posedge aclk);
  endtask : axi_write

  task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    while (arready !== 1'b1)
      @(posedge aclk);
    arvalid <= 1'b0;
    @(posedge aclk);
    while (rvalid !== 1'b1)
      @(posedge aclk);
    rready <= 1'b0;
    chk_val("rdata", ed, rdata);
    chk_val("rresp", {30'h0, er}, {30'h0, rresp});
    @(posedge aclk);
  endtask : axi_read

  // Holds a source high for hold cycles and counts request cycles seen
  task automatic pulse_cnt(input int ch, input int hold, output int n);
    n = 0;
    trig[ch] <= 1'b1;
    for (int i = 0; i < hold + 8; i++)
    begin
      @(posedge aclk);
      if (i == hold - 1)
        trig[ch] <= 1'b0;
      if (req[ch] === 1'b1)
        n++;
    end
  endtask : pulse_cnt

  // Cycles from a source rise to conversion start, and sampling drops before it
  task automatic core_lat(input int c, output int n, output int drops);
    n = 0;
    drops = 0;
    trig[c] <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (smp[c] !== 1'b1 && cstart[c] !== 1'b1)
        drops++;
    end
    while (cstart[c] !== 1'b1 && n < 200);
    trig[c] <= 1'b0;
    @(posedge aclk);
    chk_val("busy", 32'h1, {31'h0, cbusy[c]});
    repeat (12) @(posedge aclk);
    chk_val("rearm", 32'h1, {31'h0, smp[c]});
  endtask : core_lat

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (20000) @(posedge aclk);
    failures++;
    tally_and_finish();
  end

  initial
  begin
    int n, d;
    static int chs [4] = '{3, 11, 12, 14};
    static int lvl [4] = '{1, 1, 0, 1};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(`ATC_ADDR_SYNC_DELAY, 32'h0, `ATC_RESP_OKAY);
    axi_read(`ATC_ADDR_SENS, 32'h0, `ATC_RESP_OKAY);
    axi_write(`ATC_ADDR_SYNC_DELAY, 32'hFFFF_FFFF, `ATC_RESP_OKAY);
    axi_read(`ATC_ADDR_SYNC_DELAY, 32'h0000_0303, `ATC_RESP_OKAY);
    // Upper byte lane only: channel bits 7-0 keep their cleared value
    wstrb <= 4'h2;
    axi_write(`ATC_ADDR_SENS, 32'hFFFF_FFFF, `ATC_RESP_OKAY);
    axi_read(`ATC_ADDR_SENS, 32'h0000_4F00, `ATC_RESP_OKAY);
    wstrb <= 4'hF;
    axi_write(`ATC_ADDR_SENS, 32'hFFFF_FFFF, `ATC_RESP_OKAY);
    axi_read(`ATC_ADDR_SENS, 32'h0000_4FFF, `ATC_RESP_OKAY);
    axi_write(4'h8, 32'h0000_1234, `ATC_RESP_SLVERR);
    axi_read(4'h8, 32'h0, `ATC_RESP_SLVERR);
    // Level channels repeat while high; channel 12 has no level option
    for (int k = 0; k < 4; k++)
    begin
      pulse_cnt(chs[k], 6, n);
      chk_rng("level count", lvl[k] ? 6 : 1, lvl[k] ? 6 : 1, n);
    end
    axi_write(`ATC_ADDR_SENS, 32'h0, `ATC_RESP_OKAY);
    for (int k = 0; k < 4; k++)
    begin
      pulse_cnt(chs[k], 6, n);
      chk_rng("edge count", 1, 1, n);
    end
    // Edge triggers with sync cleared, immediate conversion
    axi_write(`ATC_ADDR_SYNC_DELAY, 32'h0, `ATC_RESP_OKAY);
    core_lat(0, n, d);
    chk_rng("immediate latency", 4, 8, n);
    chk_rng("sampling stopped", 1, 8, d);
    axi_write(`ATC_ADDR_SYNC_DELAY, 32'h0000_0003, `ATC_RESP_OKAY);
    core_lat(0, n, d);
    chk_rng("extended latency core0", 13, 19, n);
    chk_rng("extended sampling core0", 0, 0, d);
    core_lat(1, n, d);
    chk_rng("extended latency core1", 8, 14, n);
    // Level trigger on core 1 with sync set, slow core clock
    axi_write(`ATC_ADDR_SENS, 32'h0000_0002, `ATC_RESP_OKAY);
    axi_write(`ATC_ADDR_SYNC_DELAY, 32'h0000_0200, `ATC_RESP_OKAY);
    slow <= 1'b1;
    core_lat(1, n, d);
    chk_rng("synced latency", 4, 16, n);
    tally_and_finish();
  end
endmodule : adc_trigger_conditioning_tb

//--- verification/atc_core_model.sv
// Behavioural model of the core clocks and conversion engines beside the block
`timescale 1ns/1ps
module atc_core_model
#(
  parameter int DONE_DLY = 3
)
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       slow,
  input  wire logic [1:0] core_conv_start,
  output logic      [1:0] core_tick,
  output logic      [1:0] conv_done
);
  logic [1:0] div_ff;
  int         left_ff [2];

  // Slow mode ticks every fourth cycle so launch timing is exercised
  always_ff @(posedge aclk)
  begin
    div_ff <= aresetn ? div_ff + 2'h1 : 2'h0;
    core_tick <= (!aresetn) ? 2'h0 : ((!slow || div_ff == 2'h3) ? 2'h3 : 2'h0);
  end

  // Conversion ends only after it was started, never on its own
  always_ff @(posedge aclk)
  begin
    for (int c = 0; c < 2; c++)
    begin
      if (!aresetn || core_conv_start[c])
        left_ff[c] <= aresetn ? DONE_DLY : 0;
      else if (left_ff[c] > 0)
        left_ff[c] <= left_ff[c] - 1;
      conv_done[c] <= aresetn && (left_ff[c] == 1);
    end
  end
endmodule : atc_core_model
